/* pmt_pkg.sv */
package pmt_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 80;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCRUB_RES_NS = 40960;
  localparam int SCRUB_TICKS = SCRUB_RES_NS / TICK_NS;

  // Register offsets on the control bus (6-bit space)
  localparam logic [5:0] ADDR_TX_STATE = 6'h03;
  localparam logic [5:0] ADDR_INT_COND = 6'h07;
  localparam logic [5:0] ADDR_RX_COND_A = 6'h08;
  localparam logic [5:0] ADDR_RX_COND_B = 6'h09;
  localparam logic [5:0] ADDR_MODE2 = 6'h0f;
  localparam logic [5:0] ADDR_ST_THR = 6'h12;
  localparam logic [5:0] ADDR_PRE_THR = 6'h13;
  localparam logic [5:0] ADDR_ST_SNAP = 6'h14;
  localparam logic [5:0] ADDR_LE_THR = 6'h16;
  localparam logic [5:0] ADDR_USER = 6'h18;
  localparam logic [5:0] ADDR_REV = 6'h19;
  localparam logic [5:0] ADDR_INJ_SNAP = 6'h1a;
  localparam logic [5:0] ADDR_INJ_THR = 6'h1b;
  localparam logic [5:0] ADDR_INT_CMP = 6'h1c;
  localparam logic [5:0] ADDR_TX_CMP = 6'h1d;
  localparam logic [5:0] ADDR_RX_CMP_A = 6'h1e;
  localparam logic [5:0] ADDR_RX_CMP_B = 6'h1f;
  localparam logic [5:0] ADDR_CONN_CMP = 6'h20;
  localparam logic [5:0] ADDR_CONN_COND = 6'h21;
  localparam logic [5:0] ADDR_CONN_MASK = 6'h22;
  localparam logic [5:0] ADDR_SCRUB_THR = 6'h24;

  // Field positions
  localparam int INT_REJECT_BIT = 0;
  localparam int INT_INHIBIT_BIT = 1;
  localparam int INT_LINK_LIMIT_BIT = 2;
  localparam int TX_INJ_LSB = 2;
  localparam int RXB_SERVICE_BIT = 0;
  localparam int CONN_SCRUB_EXP_BIT = 0;
  localparam int MODE2_SCRUB_EN_BIT = 0;
  localparam int USER_SENSE_LSB = 4;
  localparam int USER_WIDTH = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Injection control codes
  localparam logic [1:0] IC_ONE_SHOT = 2'h1;
  localparam logic [1:0] IC_PERIODIC = 2'h2;

  typedef enum logic [2:0] {
    PMT_LS_QUIET = 3'h0,
    PMT_LS_IDLE = 3'h1,
    PMT_LS_MASTER = 3'h2,
    PMT_LS_HALT = 3'h3,
    PMT_LS_ACTIVE = 3'h4,
    PMT_LS_NOISE = 3'h5,
    PMT_LS_UNKNOWN = 3'h6,
    PMT_LS_NSD = 3'h7
  } pmt_line_state_t;

  typedef enum logic [1:0] {
    PMT_SCRUB_IDLE = 2'b01,
    PMT_SCRUB_RUN = 2'b10
  } pmt_scrub_state_t;
endpackage

/* pmt_tick_gen.sv */
`timescale 1ns/1ps
module pmt_tick_gen #(
  parameter int DIV = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Tick out
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = (cnt_q == LAST);
endmodule // pmt_tick_gen

/* pmt_guard_reg.sv */
`timescale 1ns/1ps
module pmt_guard_reg #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus side
  input wire logic rd,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // Hardware events
  input wire logic [W-1:0] hw_set,
  // State
  output logic [W-1:0] value,
  output logic [W-1:0] compare,
  output logic inhibit
);
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;
  logic [W-1:0] cmp_q;
  logic [W-1:0] cmp_d;
  logic [W-1:0] stale;

  always_comb begin
    stale = val_q ^ cmp_q;
    val_d = val_q;
    cmp_d = cmp_q;
    if (rd) begin
      cmp_d = val_q;
    end
    if (wr) begin
      val_d = (wdata & ~stale) | (val_q & stale);
    end
    // Hardware set beats a software clear in the same cycle
    val_d = val_d | hw_set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      val_q <= '0;
      cmp_q <= '0;
    end else begin
      val_q <= val_d;
      cmp_q <= cmp_d;
    end
  end

  assign value = val_q;
  assign compare = cmp_q;
  assign inhibit = wr && (|stale);
endmodule // pmt_guard_reg

/* pmt_mgmt_regs.sv */
// Operation
// - Prescaler counts down per tick in hold states
// - Main timer steps when prescaler zero, hold state
// - Prescaler reloads from threshold on reaching zero
// - Both zero in hold state reloads both
// - Entering a hold state reloads both timers
// - Threshold writes reload both state timers
// - State count read returns captured timer
// - Writes to read-only counts flag reject
// - Link error counter decrements per error
// - On an error at one or zero, reload threshold, set limit flag
// - Threshold write also loads link counter
// - Reset clears link and injection counters
// - Sense bits live, enable bits drive pins
// - Read-only revision register
// - Injection counter runs in one-shot/periodic
// - Injection reloads at zero and threshold write
// - Injection count read returns captured counter
// - Guarded register read copies into compare
// - Stale bits unchanged, inhibit flag set
// - Sticky connection events, masked service event
// - Scrub timer 40.96 us resolution, 8-bit
// - Scrub expiry sets expired flag
// - Scrub starts on enabled trigger only
// - Threshold write leaves running scrub alone
`timescale 1ns/1ps
module pmt_mgmt_regs
  import pmt_pkg::*;
#(
  parameter bit DUAL_PATH = 1'b1,
  parameter logic [7:0] REV_ID = 8'h01, // Value is arbitrary
  parameter int SCRUB_DIV = pmt_pkg::SCRUB_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control bus
  input wire logic [5:0] cb_addr,
  input wire logic [7:0] cb_wdata,
  input wire logic cb_rd,
  input wire logic cb_wr,
  output logic [7:0] cb_rdata,
  // Line side events
  input wire pmt_pkg::pmt_line_state_t line_state,
  input wire logic link_error,
  input wire logic [7:0] rca_event,
  input wire logic [7:0] rcb_event,
  input wire logic [7:0] cmt_event,
  input wire logic scrub_trigger,
  // User pins
  input wire logic [2:0] user_sense,
  output logic [2:0] user_enable,
  // Status
  output logic scrub_active,
  output logic [7:0] transmit_state
);
  import pmt_pkg::*;

  localparam int SW = $clog2(SCRUB_DIV + 1);
  localparam logic [SW-1:0] SCRUB_LAST = SW'(SCRUB_DIV - 1);
  localparam logic [2:0] USER_MASK = DUAL_PATH ? 3'h7 : 3'h3;

  logic tick;
  logic hold;
  logic entered;
  logic wr_ro;
  logic inhibit_any;
  logic lem_hit;
  logic scrub_done;
  logic svc_event;
  logic [4:0] inh;
  logic [7:0] int_set;
  logic [7:0] rxb_set;
  logic [7:0] conn_set;
  logic [7:0] int_cond;
  logic [7:0] int_cmp;
  logic [7:0] tx_state;
  logic [7:0] tx_cmp;
  logic [7:0] rx_a;
  logic [7:0] rx_a_cmp;
  logic [7:0] rx_b;
  logic [7:0] rx_b_cmp;
  logic [7:0] conn_cond;
  logic [7:0] conn_cmp;
  logic [7:0] rd_mux;
  logic [1:0] ic;

  // Configuration registers
  logic [7:0] st_thr_q, st_thr_d, pre_thr_q, pre_thr_d, le_thr_q, le_thr_d;
  logic [7:0] inj_thr_q, inj_thr_d;
  logic [7:0] scrub_thr_q, scrub_thr_d, mode_q, mode_d, conn_mask_q, conn_mask_d;
  logic [2:0] uen_q, uen_d;
  // Counters
  logic [7:0] st_q, st_d, spt_q, spt_d, lem_q, lem_d, inj_q, inj_d;
  pmt_line_state_t ls_prev_q, ls_prev_d;
  // Scrub
  pmt_scrub_state_t scr_q, scr_d;
  logic [7:0] scr_cnt_q, scr_cnt_d;
  logic [SW-1:0] scr_pre_q, scr_pre_d;
  // Read data
  logic [7:0] rdata_q, rdata_d;

  pmt_tick_gen #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tick)
  );

  always_comb begin
    hold = (line_state == PMT_LS_HALT) || (line_state == PMT_LS_IDLE) ||
           (line_state == PMT_LS_MASTER) || (line_state == PMT_LS_QUIET) ||
           (line_state == PMT_LS_NSD);
    entered = hold && (line_state != ls_prev_q);
    wr_ro = cb_wr && ((cb_addr == ADDR_ST_SNAP) || (cb_addr == ADDR_INJ_SNAP) ||
                      (cb_addr == ADDR_REV));
    inhibit_any = |inh;
    svc_event = |(conn_cond & conn_mask_q);
    ic = tx_state[TX_INJ_LSB +: 2];
    int_set = '0;
    int_set[INT_REJECT_BIT] = wr_ro;
    int_set[INT_INHIBIT_BIT] = inhibit_any;
    int_set[INT_LINK_LIMIT_BIT] = lem_hit;
    rxb_set = rcb_event;
    rxb_set[RXB_SERVICE_BIT] = rcb_event[RXB_SERVICE_BIT] | svc_event;
    conn_set = cmt_event;
    conn_set[CONN_SCRUB_EXP_BIT] = cmt_event[CONN_SCRUB_EXP_BIT] | scrub_done;
  end

  // Guarded registers with read-then-write protection
  pmt_guard_reg u_int_cond (
    .clk(clk), .reset_n(reset_n),
    .rd(cb_rd && cb_addr == ADDR_INT_COND), .wr(cb_wr && cb_addr == ADDR_INT_COND),
    .wdata(cb_wdata), .hw_set(int_set),
    .value(int_cond), .compare(int_cmp), .inhibit(inh[0])
  );
  pmt_guard_reg u_tx_state (
    .clk(clk), .reset_n(reset_n),
    .rd(cb_rd && cb_addr == ADDR_TX_STATE), .wr(cb_wr && cb_addr == ADDR_TX_STATE),
    .wdata(cb_wdata), .hw_set(8'h00),
    .value(tx_state), .compare(tx_cmp), .inhibit(inh[1])
  );
  pmt_guard_reg u_rx_a (
    .clk(clk), .reset_n(reset_n),
    .rd(cb_rd && cb_addr == ADDR_RX_COND_A), .wr(cb_wr && cb_addr == ADDR_RX_COND_A),
    .wdata(cb_wdata), .hw_set(rca_event),
    .value(rx_a), .compare(rx_a_cmp), .inhibit(inh[2])
  );
  pmt_guard_reg u_rx_b (
    .clk(clk), .reset_n(reset_n),
    .rd(cb_rd && cb_addr == ADDR_RX_COND_B), .wr(cb_wr && cb_addr == ADDR_RX_COND_B),
    .wdata(cb_wdata), .hw_set(rxb_set),
    .value(rx_b), .compare(rx_b_cmp), .inhibit(inh[3])
  );
  pmt_guard_reg u_conn_cond (
    .clk(clk), .reset_n(reset_n),
    .rd(cb_rd && cb_addr == ADDR_CONN_COND), .wr(cb_wr && cb_addr == ADDR_CONN_COND),
    .wdata(cb_wdata), .hw_set(conn_set),
    .value(conn_cond), .compare(conn_cmp), .inhibit(inh[4])
  );

  // Plain read/write configuration
  always_comb begin
    st_thr_d = st_thr_q;
    pre_thr_d = pre_thr_q;
    le_thr_d = le_thr_q;
    inj_thr_d = inj_thr_q;
    scrub_thr_d = scrub_thr_q;
    mode_d = mode_q;
    conn_mask_d = conn_mask_q;
    uen_d = uen_q;
    if (cb_wr) begin
      unique case (cb_addr)
        ADDR_ST_THR: st_thr_d = cb_wdata;
        ADDR_PRE_THR: pre_thr_d = cb_wdata;
        ADDR_LE_THR: le_thr_d = cb_wdata;
        ADDR_INJ_THR: inj_thr_d = cb_wdata;
        ADDR_SCRUB_THR: scrub_thr_d = cb_wdata;
        ADDR_MODE2: mode_d = cb_wdata;
        ADDR_CONN_MASK: conn_mask_d = cb_wdata;
        ADDR_USER: uen_d = cb_wdata[USER_WIDTH-1:0] & USER_MASK;
        default: ;
      endcase
    end
  end

  // State timer pair
  always_comb begin
    st_d = st_q;
    spt_d = spt_q;
    ls_prev_d = line_state;
    if ((cb_wr && (cb_addr == ADDR_ST_THR || cb_addr == ADDR_PRE_THR)) ||
        entered ||
        (hold && tick && spt_q == 8'h00 && st_q == 8'h00)) begin
      st_d = (cb_wr && cb_addr == ADDR_ST_THR) ? cb_wdata : st_thr_q;
      spt_d = (cb_wr && cb_addr == ADDR_PRE_THR) ? cb_wdata : pre_thr_q;
    end else if (hold && tick) begin
      if (spt_q == 8'h00) begin
        spt_d = pre_thr_q;
        st_d = st_q - 8'h01;
      end else begin
        spt_d = spt_q - 8'h01;
      end
    end
  end

  // Link error monitor and injection counters
  always_comb begin
    lem_d = lem_q;
    lem_hit = 1'b0;
    inj_d = inj_q;
    if (cb_wr && cb_addr == ADDR_LE_THR) begin
      lem_d = cb_wdata;
    end else if (link_error) begin
      if (lem_q <= 8'h01) begin
        lem_d = le_thr_q;
        lem_hit = 1'b1;
      end else begin
        lem_d = lem_q - 8'h01;
      end
    end
    if (cb_wr && cb_addr == ADDR_INJ_THR) begin
      inj_d = cb_wdata;
    end else if (tick && (ic == IC_ONE_SHOT || ic == IC_PERIODIC)) begin
      inj_d = (inj_q == 8'h00) ? inj_thr_q : inj_q - 8'h01;
    end
  end

  // Scrub timer: threshold is latched at start, so later writes wait
  always_comb begin
    scr_d = scr_q;
    scr_cnt_d = scr_cnt_q;
    scr_pre_d = scr_pre_q;
    scrub_done = 1'b0;
    unique case (scr_q)
      PMT_SCRUB_IDLE: begin
        if (scrub_trigger && mode_q[MODE2_SCRUB_EN_BIT]) begin
          scr_d = PMT_SCRUB_RUN;
          scr_cnt_d = scrub_thr_q;
          scr_pre_d = SCRUB_LAST;
        end
      end
      PMT_SCRUB_RUN: begin
        if (tick) begin
          if (scr_pre_q != '0) begin
            scr_pre_d = scr_pre_q - SW'(1);
          end else if (scr_cnt_q == 8'h00) begin
            scrub_done = 1'b1;
            scr_d = PMT_SCRUB_IDLE;
          end else begin
            scr_cnt_d = scr_cnt_q - 8'h01;
            scr_pre_d = SCRUB_LAST;
          end
        end
      end
    endcase
  end

  // Read path; counts are captured in the read cycle itself
  always_comb begin
    unique case (cb_addr)
      ADDR_TX_STATE: rd_mux = tx_state;
      ADDR_INT_COND: rd_mux = int_cond;
      ADDR_RX_COND_A: rd_mux = rx_a;
      ADDR_RX_COND_B: rd_mux = rx_b;
      ADDR_MODE2: rd_mux = mode_q;
      ADDR_ST_THR: rd_mux = st_thr_q;
      ADDR_PRE_THR: rd_mux = pre_thr_q;
      ADDR_ST_SNAP: rd_mux = st_q;
      ADDR_LE_THR: rd_mux = le_thr_q;
      ADDR_USER: rd_mux = {1'b0, user_sense & USER_MASK, 1'b0, uen_q};
      ADDR_REV: rd_mux = REV_ID;
      ADDR_INJ_SNAP: rd_mux = inj_q;
      ADDR_INJ_THR: rd_mux = inj_thr_q;
      ADDR_INT_CMP: rd_mux = int_cmp;
      ADDR_TX_CMP: rd_mux = tx_cmp;
      ADDR_RX_CMP_A: rd_mux = rx_a_cmp;
      ADDR_RX_CMP_B: rd_mux = rx_b_cmp;
      ADDR_CONN_CMP: rd_mux = conn_cmp;
      ADDR_CONN_COND: rd_mux = conn_cond;
      ADDR_CONN_MASK: rd_mux = conn_mask_q;
      ADDR_SCRUB_THR: rd_mux = scrub_thr_q;
      default: rd_mux = 8'h00;
    endcase
    rdata_d = cb_rd ? rd_mux : rdata_q;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_thr_q <= RST_BYTE;
      pre_thr_q <= RST_BYTE;
      le_thr_q <= RST_BYTE;
      inj_thr_q <= RST_BYTE;
      scrub_thr_q <= RST_BYTE;
      mode_q <= RST_BYTE;
      conn_mask_q <= RST_BYTE;
      uen_q <= '0;
      st_q <= RST_BYTE;
      spt_q <= RST_BYTE;
      lem_q <= RST_BYTE;
      inj_q <= RST_BYTE;
      ls_prev_q <= PMT_LS_QUIET;
      scr_q <= PMT_SCRUB_IDLE;
      scr_cnt_q <= RST_BYTE;
      scr_pre_q <= '0;
      rdata_q <= RST_BYTE;
    end else begin
      st_thr_q <= st_thr_d;
      pre_thr_q <= pre_thr_d;
      le_thr_q <= le_thr_d;
      inj_thr_q <= inj_thr_d;
      scrub_thr_q <= scrub_thr_d;
      mode_q <= mode_d;
      conn_mask_q <= conn_mask_d;
      uen_q <= uen_d;
      st_q <= st_d;
      spt_q <= spt_d;
      lem_q <= lem_d;
      inj_q <= inj_d;
      ls_prev_q <= ls_prev_d;
      scr_q <= scr_d;
      scr_cnt_q <= scr_cnt_d;
      scr_pre_q <= scr_pre_d;
      rdata_q <= rdata_d;
    end
  end

  assign cb_rdata = rdata_q;
  assign user_enable = uen_q;
  assign scrub_active = (scr_q == PMT_SCRUB_RUN);
  assign transmit_state = tx_state;
endmodule // pmt_mgmt_regs

/* pmt_mgmt_regs_assertions.sv */
`timescale 1ns/1ps
module pmt_mgmt_regs_assertions
  import pmt_pkg::*;
#(
  parameter logic [7:0] REV_ID = 8'h01,
  parameter int SCRUB_DIV = 512
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control bus
  input wire logic [5:0] cb_addr,
  input wire logic [7:0] cb_wdata,
  input wire logic cb_rd,
  input wire logic cb_wr,
  input wire logic [7:0] cb_rdata,
  // Pins
  input wire logic scrub_trigger,
  input wire logic [2:0] user_sense,
  input wire logic [2:0] user_enable,
  input wire logic scrub_active,
  input wire logic [7:0] transmit_state
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] cmp_q;
  logic [7:0] cmp_d;
  logic [7:0] ts_exp;
  // Shadow of the transmit-state compare copy
  always_comb begin
    cmp_d = (cb_rd && cb_addr == ADDR_TX_STATE) ? transmit_state : cmp_q;
    if (!reset_n) cmp_d = 8'h00;
    ts_exp = (cb_wdata & ~(transmit_state ^ cmp_q)) | (transmit_state & (transmit_state ^ cmp_q));
  end
  always_ff @(posedge clk) begin
    cmp_q <= cmp_d;
  end
  sequence s_tx_rd;
    cb_rd && cb_addr == ADDR_TX_STATE;
  endsequence
  sequence s_tx_wr;
    cb_wr && cb_addr == ADDR_TX_STATE;
  endsequence
  a_rev_read_value: assert property (cb_rd && cb_addr == ADDR_REV |=> cb_rdata == REV_ID)
    else $error("revision read wrong");
  a_enable_follow_write: assert property (cb_wr && cb_addr == ADDR_USER |=>
    user_enable == $past(cb_wdata[2:0])) else $error("enable pins wrong");
  a_enable_hold: assert property (!(cb_wr && cb_addr == ADDR_USER) |=> $stable(user_enable))
    else $error("enable pins moved");
  a_sense_live: assert property (cb_rd && cb_addr == ADDR_USER |=>
    cb_rdata[6:4] == $past(user_sense)) else $error("sense bits wrong");
  a_tx_read_copy: assert property (s_tx_rd |=> cb_rdata == $past(transmit_state))
    else $error("transmit state read wrong");
  a_tx_guard_write: assert property (s_tx_wr |=> transmit_state == $past(ts_exp))
    else $error("guarded write wrong");
  a_tx_no_stray: assert property (!(cb_wr && cb_addr == ADDR_TX_STATE) |=>
    $stable(transmit_state)) else $error("transmit state moved");
  a_scrub_needs_trig: assert property ($rose(scrub_active) |-> $past(scrub_trigger))
    else $error("scrub without trigger");
  a_rdata_holds: assert property (!cb_rd |=> $stable(cb_rdata))
    else $error("read data moved");
  a_reset_clears: assert property (disable iff (1'b0) !reset_n |=>
    cb_rdata == 8'h00 && !scrub_active && transmit_state == 8'h00) else $error("reset state");
endmodule // pmt_mgmt_regs_assertions

bind pmt_mgmt_regs pmt_mgmt_regs_assertions #(.REV_ID(REV_ID), .SCRUB_DIV(SCRUB_DIV))
  i_pmt_mgmt_regs_assertions (.clk, .reset_n, .cb_addr, .cb_wdata, .cb_rd, .cb_wr, .cb_rdata,
  .scrub_trigger, .user_sense, .user_enable, .scrub_active, .transmit_state);

/* pmt_host_model.sv */
`timescale 1ns/1ps
module pmt_host_model (
  // Clock
  input wire logic clk,
  // Control bus
  output logic [5:0] cb_addr,
  output logic [7:0] cb_wdata,
  output logic cb_rd,
  output logic cb_wr,
  input wire logic [7:0] cb_rdata
);
  initial begin
    cb_addr = 6'h00;
    cb_wdata = 8'h00;
    cb_rd = 1'b0;
    cb_wr = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    cb_addr <= a;
    cb_wdata <= d;
    cb_wr <= 1'b1;
    @(posedge clk);
    cb_wr <= 1'b0;
    // Idle lines never keep the last value
    cb_addr <= ~a;
    cb_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    cb_addr <= a;
    cb_rd <= 1'b1;
    @(posedge clk);
    cb_rd <= 1'b0;
    cb_addr <= ~a;
    #1 d = cb_rdata;
  endtask
  // Read first so the compare copy matches
  task automatic gwr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] t;
    rd(a, t);
    wr(a, d);
  endtask
endmodule // pmt_host_model

/* phy_mgmt_timers_and_guarded_regs_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== 8'(e)) begin failures++; \
  $display("[ERR] %s exp %0h got %0h", nm, 8'(e), g); end end
module phy_mgmt_timers_and_guarded_regs_bench;
  import pmt_pkg::*;
  localparam logic [7:0] REV = 8'h5a; // Value is arbitrary
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] cb_addr;
  logic [7:0] cb_wdata, cb_rdata, transmit_state, d;
  logic cb_rd, cb_wr, scrub_active, link_error = 1'b0, scrub_trigger = 1'b0;
  logic [2:0] user_sense = 3'h0, user_enable;
  pmt_line_state_t line_state = PMT_LS_ACTIVE;
  int failures = 0, n_compared = 0, cyc = 0, cycles = 0, seed = 32'h317a0625, v, w, n;
  int ks[$] = '{1, 3, 4, 6};
  pmt_mgmt_regs #(.REV_ID(REV), .SCRUB_DIV(4)) i_pmt_mgmt_regs (.clk, .reset_n, .cb_addr,
    .cb_wdata, .cb_rd, .cb_wr, .cb_rdata, .line_state, .link_error, .rca_event(8'h00),
    .rcb_event(8'h00), .cmt_event(8'h00), .scrub_trigger, .user_sense, .user_enable,
    .scrub_active, .transmit_state);
  pmt_host_model i_pmt_host_model (.clk, .cb_addr, .cb_wdata, .cb_rd, .cb_wr, .cb_rdata);
  always #4 clk = ~clk;
  // Tick phase: ticks land where cyc ends in nine
  always @(posedge clk) cyc <= reset_n ? cyc + 1 : 0;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Timer model: one step per tick, reload when both reach zero
  function automatic int tmr(int k, int thr, int pre, bit hold);
    int st = thr;
    int sp = pre;
    if (hold) repeat (k) begin
      if (sp != 0) sp--;
      else if (st == 0) begin st = thr; sp = pre; end
      else begin st--; sp = pre; end
    end
    return st;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] x);
    i_pmt_host_model.wr(a, x);
    #1;
  endtask
  task automatic gw(input logic [5:0] a, input logic [7:0] x);
    i_pmt_host_model.gwr(a, x);
    #1;
  endtask
  task automatic rchk(input logic [5:0] a, input int e, input string nm);
    i_pmt_host_model.rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic align();
    do begin
      @(posedge clk);
      #1;
    end while (cyc % 10 != 3);
  endtask
  task automatic lerr();
    @(posedge clk);
    link_error <= 1'b1;
    @(posedge clk);
    link_error <= 1'b0;
  endtask
  task automatic trig();
    @(posedge clk);
    scrub_trigger <= 1'b1;
    @(posedge clk);
    scrub_trigger <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rchk(ADDR_INJ_SNAP, 0, "inj_reset");
    rchk(ADDR_REV, REV, "rev_id");
    wr(ADDR_REV, 8'h55);
    wr(ADDR_ST_SNAP, 8'h55);
    wr(ADDR_INJ_SNAP, 8'h55);
    rchk(ADDR_REV, REV, "rev_kept");
    rchk(ADDR_INT_COND, 8'h01, "int_reject");
    wr(ADDR_INT_COND, 8'h00);
    rchk(ADDR_INT_COND, 0, "int_clear");
    repeat (4) begin
      v = $random(seed);
      @(posedge clk);
      user_sense <= v[6:4];
      wr(ADDR_USER, v[7:0]);
      `CHK("enable", v[2:0], user_enable)
      rchk(ADDR_USER, {v[6:4], 1'b0, v[2:0]}, "user_reg");
    end
    v = ($random(seed) & 8'hf3) | 8'h10;
    w = $random(seed) & 8'hf3;
    gw(ADDR_TX_STATE, v[7:0]);
    `CHK("tx_state", v, transmit_state)
    wr(ADDR_TX_STATE, w[7:0]);
    `CHK("tx_guard", w | v, transmit_state)
    rchk(ADDR_INT_COND, 8'h02, "int_inhibit");
    wr(ADDR_INT_COND, 8'h00);
    wr(ADDR_LE_THR, 8'h03);
    lerr();
    lerr();
    rchk(ADDR_INT_COND, 0, "lem_early");
    lerr();
    rchk(ADDR_INT_COND, 8'h04, "lem_limit");
    wr(ADDR_INT_COND, 8'h00);
    wr(ADDR_PRE_THR, 8'h01);
    foreach (ks[i]) begin
      align();
      if (i == 2) begin
        @(posedge clk);
        line_state <= PMT_LS_IDLE;
      end else wr(ADDR_ST_THR, 8'h02);
      repeat (ks[i]) align();
      rchk(ADDR_ST_SNAP, tmr(ks[i], 2, 1, i > 1), "state_cnt");
    end
    for (int ic = 0; ic < 3; ic++) begin
      gw(ADDR_TX_STATE, 8'(ic << 2));
      align();
      wr(ADDR_INJ_THR, 8'h05);
      repeat (7) align();
      rchk(ADDR_INJ_SNAP, tmr(7, 5, 0, ic != 0), "inj_cnt");
    end
    wr(ADDR_MODE2, 8'h00);
    trig();
    repeat (20) @(posedge clk);
    `CHK("scrub_off", 0, scrub_active)
    wr(ADDR_CONN_MASK, 8'h01);
    wr(ADDR_SCRUB_THR, 8'h01);
    wr(ADDR_MODE2, 8'h01);
    trig();
    repeat (20) @(posedge clk);
    wr(ADDR_SCRUB_THR, 8'hc8);
    n = 22;
    while (scrub_active === 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("scrub_len", 1, n >= 70 && n <= 91)
    rchk(ADDR_CONN_COND, 8'h01, "scrub_exp");
    rchk(ADDR_RX_COND_B, 8'h01, "svc_event");
    complete_run();
  end
endmodule // phy_mgmt_timers_and_guarded_regs_bench
